// ==== core/oef_flag_store.sv ====
// Sticky write-one-to-clear event flag register.
`timescale 1ns/100ps
`include "oef_map.svh"
module oef_flag_store (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	oef_ev_if.dst     ev
);
	import oef_pkg::*;
	oef_word_t flags;
	oef_word_t next_flags;
	oef_word_t set_v;

	always_comb begin
		set_v = '0;
		set_v[`OEF_BIT_SR_DONE]   = ev.sr_done;   // R8
		set_v[`OEF_BIT_RS_DONE]   = ev.rs_done;   // R7
		set_v[`OEF_BIT_RS_SEEN]   = ev.rs_seen;   // R6
		set_v[`OEF_BIT_A_TIMEOUT] = ev.a_timeout; // R5
		set_v[`OEF_BIT_DEB_DONE]  = ev.deb_done;  // R4
		set_v[`OEF_BIT_SES_END]   = ev.ses_end;   // R9
		// A new event beats a clear in the same cycle so nothing is lost.
		next_flags = ((flags & ~ev.clr_mask) | set_v) & `OEF_FLAGS_MASK; // R3
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			flags <= `OEF_RST_FLAGS; // R10
		end else begin
			flags <= next_flags;
		end
	end

	assign ev.flags = flags;
endmodule // oef_flag_store

// ==== core/oef_top.sv ====
// OTG event flags and interrupt configuration with an APB slave.
//
// Summary of operation
// R1 - In device mode a successful session request sets the success bit.
// R2 - Setting the session request start bit clears the success bit.
// R3 - Event flags read latched state, write one clears, zero keeps.
// R4 - In host mode finished debounce sets the debounce flag at bit 19.
// R5 - Expiry of the A-side wait for connection sets bit 18.
// R6 - A role swap request seen while A-side sets bit 17.
// R7 - End of a role swap negotiation sets bit 9.
// R8 - End of a session request procedure sets bit 8.
// R9 - Bus supply below session valid threshold sets bit 2.
// R10 - The event flag register sits at 0x0004 and resets to zero.
// R11 - Host periodic empty interrupt fires half empty on 0, empty on 1.
// R12 - Device IN empty interrupt fires half empty on 0, empty on 1.
// R13 - Host nonperiodic empty interrupt follows the same bit 7.
// R14 - Global enable bit 0 gates the interrupt output and resets to 0.
// R15 - Software writes reserved bits with their reset value.
// R16 - Role swap success sets on success, clears when request is set.
// R17 - Start bit is set by software and cleared by zero or flag clear.
`timescale 1ns/100ps
`include "oef_map.svh"
module oef_top (
	input  wire logic                 i_clk,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [11:0]          i_paddr,
	input  wire oef_pkg::oef_word_t   i_pwdata,
	output logic                      o_pready,
	output logic                      o_pslverr,
	output oef_pkg::oef_word_t        o_prdata,
	input  wire logic                 i_host_mode,
	input  wire logic                 i_sr_done,
	input  wire logic                 i_sr_ok,
	input  wire logic                 i_rs_done,
	input  wire logic                 i_rs_ok,
	input  wire logic                 i_rs_seen,
	input  wire logic                 i_a_timeout,
	input  wire logic                 i_deb_done,
	input  wire logic                 i_ses_end,
	input  wire logic                 i_core_irq,
	output logic                      o_irq,
	output logic                      o_sr_start,
	output logic                      o_rs_request,
	output logic                      o_ptx_level_empty,
	output logic                      o_inep_level_empty,
	output logic                      o_nptx_level_empty
);
	import oef_pkg::*;

	oef_apb_state_t state;
	oef_apb_state_t next_state;
	oef_word_t      ctrl;
	oef_word_t      next_ctrl;
	oef_word_t      cfg;
	oef_word_t      next_cfg;
	oef_word_t      next_prdata;
	logic           next_pready;
	logic           next_pslverr;
	logic           next_irq;
	logic           next_ptx;
	logic           next_inep;
	logic           next_nptx;
	logic           wr_go;
	logic           rd_go;
	logic           hit;
	oef_word_t      wflags;

	oef_ev_if ev ();

	oef_flag_store u_flags (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.ev        (ev)
	);

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `OEF_OFF_CTRL) || (a == `OEF_OFF_FLAGS) ||
			(a == `OEF_OFF_CFG);
	endfunction

	// The answer comes in the first access cycle, one cycle after setup.
	assign wr_go = (state == OEF_ACCESS) && i_psel && i_penable && i_pwrite;
	assign rd_go = (state == OEF_ACCESS) && i_psel && i_penable && !i_pwrite;
	assign hit   = is_mapped(i_paddr);

	always_comb begin
		wflags = '0;
		if (wr_go && (i_paddr == `OEF_OFF_FLAGS)) begin
			wflags = i_pwdata & `OEF_FLAGS_MASK; // R3
		end
		ev.clr_mask  = wflags;
		ev.sr_done   = i_sr_done;
		ev.rs_done   = i_rs_done;
		ev.rs_seen   = i_rs_seen;
		ev.a_timeout = i_a_timeout;
		ev.deb_done  = i_deb_done && i_host_mode; // R4
		ev.ses_end   = i_ses_end;
	end

	always_comb begin
		next_state = state;
		unique case (state)
			OEF_IDLE: begin
				if (i_psel && !i_penable) begin
					next_state = OEF_ACCESS;
				end
			end
			OEF_ACCESS: begin
				next_state = OEF_IDLE;
			end
		endcase
	end

	always_comb begin
		next_pready  = (state == OEF_IDLE) && i_psel && !i_penable;
		next_pslverr = (state == OEF_IDLE) && i_psel && !i_penable &&
			!is_mapped(i_paddr);
		next_prdata  = '0;
		if ((state == OEF_IDLE) && i_psel && !i_penable && !i_pwrite) begin
			unique case (i_paddr)
				`OEF_OFF_CTRL:  next_prdata = ctrl;
				`OEF_OFF_FLAGS: next_prdata = ev.flags; // R3
				`OEF_OFF_CFG:   next_prdata = cfg;
				default:        next_prdata = '0;
			endcase
		end
	end

	always_comb begin
		next_ctrl = ctrl;
		next_cfg  = cfg;
		if (wr_go && (i_paddr == `OEF_OFF_CFG)) begin
			// Reserved bits are masked; software keeps them zero anyway.
			next_cfg = i_pwdata & `OEF_CFG_MASK; // R15
		end
		if (wr_go && (i_paddr == `OEF_OFF_CTRL)) begin
			next_ctrl[`OEF_BIT_SR_START]   = i_pwdata[`OEF_BIT_SR_START];
			next_ctrl[`OEF_BIT_RS_REQUEST] = i_pwdata[`OEF_BIT_RS_REQUEST];
			if (i_pwdata[`OEF_BIT_SR_START] && !ctrl[`OEF_BIT_SR_START]) begin
				next_ctrl[`OEF_BIT_SR_SUCCESS] = 1'b0; // R2
			end
			if (i_pwdata[`OEF_BIT_RS_REQUEST] &&
				!ctrl[`OEF_BIT_RS_REQUEST]) begin
				next_ctrl[`OEF_BIT_RS_SUCCESS] = 1'b0; // R16
			end
		end
		// Clearing the done flag also withdraws the pending request.
		if (wflags[`OEF_BIT_SR_DONE] && ev.flags[`OEF_BIT_SR_DONE]) begin
			next_ctrl[`OEF_BIT_SR_START] = 1'b0; // R17
		end
		if (wflags[`OEF_BIT_RS_DONE] && ev.flags[`OEF_BIT_RS_DONE]) begin
			next_ctrl[`OEF_BIT_RS_REQUEST] = 1'b0; // R17
		end
		// Success is sampled with the done strobe; the set wins a clear.
		if (i_sr_done && i_sr_ok && !i_host_mode) begin
			next_ctrl[`OEF_BIT_SR_SUCCESS] = 1'b1; // R1
		end
		if (i_rs_done && i_rs_ok) begin
			next_ctrl[`OEF_BIT_RS_SUCCESS] = 1'b1; // R16
		end
		next_ctrl = next_ctrl & `OEF_CTRL_MASK;
	end

	always_comb begin
		next_irq  = i_core_irq && cfg[`OEF_BIT_IRQ_EN]; // R14
		next_ptx  = i_host_mode && cfg[`OEF_BIT_PTX_LVL]; // R11
		next_inep = !i_host_mode && cfg[`OEF_BIT_TX_LVL]; // R12
		next_nptx = i_host_mode && cfg[`OEF_BIT_TX_LVL]; // R13
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state              <= OEF_IDLE;
			ctrl               <= `OEF_RST_CTRL;
			cfg                <= `OEF_RST_CFG; // R14
			o_pready           <= 1'b0;
			o_pslverr          <= 1'b0;
			o_prdata           <= '0;
			o_irq              <= 1'b0;
			o_ptx_level_empty  <= 1'b0;
			o_inep_level_empty <= 1'b0;
			o_nptx_level_empty <= 1'b0;
			o_sr_start         <= 1'b0;
			o_rs_request       <= 1'b0;
		end else begin
			state              <= next_state;
			ctrl               <= next_ctrl;
			cfg                <= next_cfg;
			o_pready           <= next_pready;
			o_pslverr          <= next_pslverr;
			o_prdata           <= next_prdata;
			o_irq              <= next_irq;
			o_ptx_level_empty  <= next_ptx;
			o_inep_level_empty <= next_inep;
			o_nptx_level_empty <= next_nptx;
			o_sr_start         <= next_ctrl[`OEF_BIT_SR_START];
			o_rs_request       <= next_ctrl[`OEF_BIT_RS_REQUEST];
		end
	end

	logic unused_hit;
	assign unused_hit = hit & rd_go;
endmodule // oef_top

// ==== shared/oef_ev_if.sv ====
// Event strobes passed from the top to the flag store.
`timescale 1ns/100ps
interface oef_ev_if;
	logic        sr_done;
	logic        rs_done;
	logic        rs_seen;
	logic        a_timeout;
	logic        deb_done;
	logic        ses_end;
	logic [31:0] clr_mask;
	logic [31:0] flags;
	modport src (output sr_done, rs_done, rs_seen, a_timeout, deb_done,
		ses_end, clr_mask, input flags);
	modport dst (input sr_done, rs_done, rs_seen, a_timeout, deb_done,
		ses_end, clr_mask, output flags);
endinterface

// ==== shared/oef_map.svh ====
// Register offsets, field positions and reset values of the OTG event block.
`ifndef OEF_MAP_SVH
`define OEF_MAP_SVH
`define OEF_OFF_CTRL        12'h000
`define OEF_OFF_FLAGS       12'h004
`define OEF_OFF_CFG         12'h008
`define OEF_BIT_SR_SUCCESS  0
`define OEF_BIT_SR_START    1
`define OEF_BIT_RS_SUCCESS  8
`define OEF_BIT_RS_REQUEST  9
`define OEF_BIT_SES_END     2
`define OEF_BIT_SR_DONE     8
`define OEF_BIT_RS_DONE     9
`define OEF_BIT_RS_SEEN     17
`define OEF_BIT_A_TIMEOUT   18
`define OEF_BIT_DEB_DONE    19
`define OEF_BIT_IRQ_EN      0
`define OEF_BIT_TX_LVL      7
`define OEF_BIT_PTX_LVL     8
`define OEF_FLAGS_MASK      32'h000e0304
`define OEF_CFG_MASK        32'h00000181
`define OEF_CTRL_MASK       32'h00000303
`define OEF_RST_FLAGS       32'h00000000
`define OEF_RST_CFG         32'h00000000
`define OEF_RST_CTRL        32'h00000000
`endif

// ==== shared/oef_pkg.sv ====
// Types shared by the OTG event block.
package oef_pkg;
	typedef logic [31:0] oef_word_t;
	typedef enum logic [1:0] {
		OEF_IDLE   = 2'b00,
		OEF_ACCESS = 2'b01
	} oef_apb_state_t;
endpackage

// ==== tb/oef_peer.sv ====
// Model of the OTG peer and bus monitor that raise negotiation events.
`timescale 1ns/100ps
module oef_peer (
	input  wire logic       i_clk,
	input  wire logic [5:0] i_kick,
	input  wire logic       i_ok,
	output logic [5:0]      o_ev,
	output logic            o_ok
);
	// Events are one-cycle strobes so a stuck level never hides a clear.
	always_ff @(posedge i_clk) begin
		o_ev <= i_kick;
		o_ok <= i_ok;
	end
endmodule // oef_peer

// ==== tb/oef_top_props.sv ====
// Port-level assertions for the OTG event flag block.
`timescale 1ns/100ps
module oef_top_props (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_host_mode,
	input wire logic i_core_irq,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire oef_pkg::oef_word_t o_prdata,
	input wire logic o_irq,
	input wire logic o_sr_start,
	input wire logic o_rs_request,
	input wire logic o_ptx_level_empty,
	input wire logic o_inep_level_empty,
	input wire logic o_nptx_level_empty
);
	import oef_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_answer;
		i_psel && i_penable && o_pready;
	endsequence
	a_setup_answered: assert property (s_setup |=> s_answer)
		else $error("setup not answered");
	a_ready_single: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_rdata_quiet: assert property (!o_pready |-> o_prdata == '0)
		else $error("read data outside answer");
	a_irq_gated: assert property (o_irq |-> $past(i_core_irq))
		else $error("interrupt without source");
	a_ptx_host_only: assert property (o_ptx_level_empty |-> $past(i_host_mode))
		else $error("periodic level outside host mode");
	a_inep_dev_only: assert property (o_inep_level_empty |-> !$past(i_host_mode))
		else $error("endpoint level outside device mode");
	a_nptx_host_only: assert property (o_nptx_level_empty |-> $past(i_host_mode))
		else $error("nonperiodic level outside host mode");
	a_reset_clean: assert property ($fell(i_sys_rst) |-> !o_irq && !o_sr_start && !o_rs_request)
		else $error("outputs active after reset");
endmodule // oef_top_props
bind oef_top oef_top_props i_oef_top_props (.i_clk, .i_sys_rst, .i_psel,
	.i_penable, .i_host_mode, .i_core_irq, .o_pready, .o_pslverr, .o_prdata,
	.o_irq, .o_sr_start, .o_rs_request, .o_ptx_level_empty,
	.o_inep_level_empty, .o_nptx_level_empty);

// ==== tb/oef_top_tb.sv ====
// Self-checking bench for the OTG event flag and interrupt block.
`timescale 1ns/100ps
`include "oef_map.svh"
module oef_top_tb;
	import oef_pkg::*;
	localparam int POS[6] = '{8, 9, 17, 18, 19, 2};
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, host = 0, cirq = 0;
	logic ok = 0, rdy, serr, e, irq, srs, rsr, ptx, inep, nptx, okp;
	logic [11:0] paddr = 0;
	logic [5:0] kick = 0, ev;
	oef_word_t pwdata = 0, prdata, q, d;
	int err_total = 0, checks = 0, i, seed = 32'h7970e00d;
	oef_top i_oef_top (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(rdy), .o_pslverr(serr), .o_prdata(prdata),
		.i_host_mode(host), .i_sr_done(ev[0]), .i_sr_ok(okp),
		.i_rs_done(ev[1]), .i_rs_ok(okp), .i_rs_seen(ev[2]),
		.i_a_timeout(ev[3]), .i_deb_done(ev[4]), .i_ses_end(ev[5]),
		.i_core_irq(cirq), .o_irq(irq), .o_sr_start(srs),
		.o_rs_request(rsr), .o_ptx_level_empty(ptx),
		.o_inep_level_empty(inep), .o_nptx_level_empty(nptx));
	oef_peer i_oef_peer (.i_clk(clk), .i_kick(kick), .i_ok(ok), .o_ev(ev),
		.o_ok(okp));
	initial forever #5 clk = ~clk;
	task automatic chk(input string s, input oef_word_t x, input oef_word_t g);
		checks++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", s, x, g);
		end
	endtask
	// The request holds until pready is sampled; an idle edge then follows.
	task automatic apb(input logic w, input logic [11:0] a, input oef_word_t v);
		int n;
		logic got;
		n = 0;
		got = 0;
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		pen <= 1;
		// Answer is read mid-cycle, where it has settled before its edge.
		do begin
			@(negedge clk);
			got = rdy;
			q = prdata;
			e = serr;
			@(posedge clk);
			n++;
		end while (got !== 1'b1 && n < 20);
		if (n >= 20) err_total++;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	task automatic fire(input int k, input logic g);
		kick <= 6'(1 << k);
		ok <= g;
		@(posedge clk);
		kick <= 0;
		repeat (2) @(posedge clk);
	endtask
	function automatic oef_word_t pins(input oef_word_t c);
		return {c[30] & c[0], c[31] & c[8], !c[31] & c[7], c[31] & c[7]};
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		apb(0, `OEF_OFF_FLAGS, 0);
		chk("flags", 0, q);
		apb(0, `OEF_OFF_CFG, 0);
		chk("cfg", 0, q);
		host <= 1;
		for (i = 0; i < 6; i++) begin
			fire(i, 1);
			apb(0, `OEF_OFF_FLAGS, 0);
			chk("flag_set", 32'h1 << POS[i], q);
			apb(1, `OEF_OFF_FLAGS, 0);
			apb(0, `OEF_OFF_FLAGS, 0);
			chk("flag_kept", 32'h1 << POS[i], q);
			apb(1, `OEF_OFF_FLAGS, 32'h1 << POS[i]);
			apb(0, `OEF_OFF_FLAGS, 0);
			chk("flag_clear", 0, q);
		end
		host <= 0;
		fire(4, 1);
		apb(0, `OEF_OFF_FLAGS, 0);
		chk("deb_device", 0, q);
		$display("event test done");
		// The role swap event above left its success bit set; drop it first.
		apb(1, `OEF_OFF_CTRL, 32'h200);
		apb(1, `OEF_OFF_CTRL, 0);
		apb(0, `OEF_OFF_CTRL, 0);
		chk("ctrl_idle", 0, q);
		for (i = 0; i < 2; i++) begin
			d = i ? 32'h200 : 32'h2;
			apb(1, `OEF_OFF_CTRL, d);
			@(posedge clk);
			chk("req_pin", 1, i ? rsr : srs);
			fire(i, 1);
			apb(0, `OEF_OFF_CTRL, 0);
			chk("success", d | (d >> 1), q);
			apb(1, `OEF_OFF_CTRL, 0);
			apb(1, `OEF_OFF_CTRL, d);
			apb(0, `OEF_OFF_CTRL, 0);
			chk("restart", d, q);
			apb(1, `OEF_OFF_FLAGS, 32'h1 << POS[i]);
			apb(0, `OEF_OFF_CTRL, 0);
			chk("req_drop", 0, q);
		end
		$display("handshake test done");
		for (i = 0; i < 8; i++) begin
			d = i ? $random(seed) : '1;
			host <= d[31];
			cirq <= d[30];
			apb(1, `OEF_OFF_CFG, d & `OEF_CFG_MASK);
			apb(0, `OEF_OFF_CFG, 0);
			chk("cfg_rw", d & `OEF_CFG_MASK, q);
			chk("pins", pins(d), {irq, ptx, inep, nptx});
		end
		$display("config test done");
		apb(0, 12'h00c, 0);
		chk("unmapped_err", 1, e);
		chk("unmapped_data", 0, q);
		wrap_up();
	end
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		wrap_up();
	end
endmodule // oef_top_tb
